// File: core/dcc_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the dual comparator control block. Definitions only.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ============================================================
// Register byte addresses
`define DCC_OFS_CMP_CTRL    12'h000
`define DCC_OFS_LADDER_CTRL 12'h004
`define DCC_OFS_IRQ_STATUS  12'h008
`define DCC_OFS_IRQ_MASK    12'h00c
`define DCC_OFS_MODE        12'h010

// ============================================================
// Comparator control field positions
`define DCC_B_IDLE_SUPP    15
`define DCC_B_RSVD14       14
`define DCC_B_B_FLAG       13
`define DCC_B_A_FLAG       12
`define DCC_B_B_ON         11
`define DCC_B_A_ON         10
`define DCC_B_B_PAD        9
`define DCC_B_A_PAD        8
`define DCC_B_B_RESULT     7
`define DCC_B_A_RESULT     6
`define DCC_B_B_INV        5
`define DCC_B_A_INV        4
`define DCC_B_B_MINUS      3
`define DCC_B_B_PLUS       2
`define DCC_B_A_MINUS      1
`define DCC_B_A_PLUS       0

// ============================================================
// Reference ladder field positions
`define DCC_B_LAD_POWER    7
`define DCC_B_LAD_PIN      6
`define DCC_B_LAD_RANGE    5
`define DCC_B_LAD_SOURCE   4
`define DCC_B_LAD_CODE_HI  3

// ============================================================
// Reset values and write masks
`define DCC_RST_CMP_CTRL    16'h0000
`define DCC_RST_LADDER_CTRL 16'h0000
`define DCC_WMASK_CMP       16'hbf3f
`define DCC_WMASK_LADDER    16'h00ff

// ============================================================
// Synchroniser depth
`define DCC_SYNC_STAGES    2

`endif

// File: core/dcc_pkg.sv
// Types shared by the dual comparator control block.
// Assumes dcc_defines.svh holds the numeric constants.
package dcc_pkg;

  // ============================================================
  // Reference range chosen by the ladder range bit
  typedef enum logic [0:0] {
    DCC_RANGE_QUARTER = 1'b0,
    DCC_RANGE_ZERO    = 1'b1
  } dcc_range_e;

  // ============================================================
  // Ladder tap index, one of sixteen levels per range
  typedef logic [3:0] dcc_code_t;

endpackage : dcc_pkg

// File: core/dcc_top.sv
// Dual comparator control: APB register slave, routing and ladder controls,
// synchronised result bits, change flags and a level interrupt.
// Assumes analog outputs are asynchronous and pclk is the only clock.
//
// Contract
// RULE1: Idle suppression blocks interrupts, comparators stay on
// RULE2: Output change sets that comparator's flag
// RULE3: Enable bits turn comparators on or off
// RULE4: Pad drive bits gate comparator pad output
// RULE5: Result bits read comparison, sense per inversion
// RULE6: Inversion bits invert comparator output
// RULE7: Minus select routes negative terminal
// RULE8: Plus select picks pin or internal reference
// RULE9: Ladder power bit powers reference circuit
// RULE10: Ladder pin bit connects reference to pin
// RULE11: Range bit picks step size and offset
// RULE12: Source bit picks reference span
// RULE13: Four-bit level code, sixteen levels per range
// RULE14: Unimplemented bits read zero, ignore writes
// RULE15: Flags sticky until cleared; interrupt while set
// RULE16: Two-stage synchroniser before using outputs
`timescale 1ns/1ns
`include "dcc_defines.svh"

module dcc_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Chip power state
  input  wire logic              idle_mode,
  // Raw analog comparator outputs
  input  wire logic              cmp_a_raw,
  input  wire logic              cmp_b_raw,
  // Comparator controls
  output logic                   cmp_a_on,
  output logic                   cmp_b_on,
  output logic                   cmp_a_minus_select,
  output logic                   cmp_b_minus_select,
  output logic                   cmp_a_plus_select,
  output logic                   cmp_b_plus_select,
  // Output pads, enables active low
  output logic                   cmp_a_pad_out,
  output logic                   cmp_a_pad_oe_n,
  output logic                   cmp_b_pad_out,
  output logic                   cmp_b_pad_oe_n,
  // Reference ladder controls
  output logic                   ladder_power_on,
  output logic                   ladder_pin_drive,
  output logic                   ladder_range_select,
  output logic                   ladder_source_select,
  output logic [3:0]             ladder_level_code,
  // Interrupt
  output logic                   irq
);

  // ============================================================
  // Elaboration check
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("dcc_top: ADDR_W must be at least 5");
  end
  // The change detector expects results exactly two edges after the pins
  if (`DCC_SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("dcc_top: synchroniser depth must be two");
  end

  // ============================================================
  // State
  logic [15:0] cmp_ctrl_r;
  logic [15:0] ladder_ctrl_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic        mode_int_en_r;
  logic [1:0]  sync1_r;
  logic [1:0]  sync2_r;
  logic [1:0]  prev_r;
  logic        prev_valid_r;

  // ============================================================
  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic [ADDR_W-1:0] addr_w;
  logic        hit;
  logic [15:0] wdata16;
  logic [15:0] strb16;

  // Every register is one aligned word; the byte lane bits are ignored
  assign addr_w  = {paddr[ADDR_W-1:2], 2'b00};
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign wdata16 = pwdata[15:0];
  assign strb16  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready  = 1'b1;

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    is_addr = (a == ADDR_W'(ofs));
  endfunction : is_addr

  // Low-byte write strobe for one register; the narrow registers live there
  function automatic logic reg_wr(input logic [11:0] ofs);
    reg_wr = wr_en && pstrb[0] && is_addr(addr_w, ofs);
  endfunction : reg_wr

  assign hit = is_addr(addr_w, `DCC_OFS_CMP_CTRL) || is_addr(addr_w, `DCC_OFS_LADDER_CTRL)
            || is_addr(addr_w, `DCC_OFS_IRQ_STATUS) || is_addr(addr_w, `DCC_OFS_IRQ_MASK)
            || is_addr(addr_w, `DCC_OFS_MODE);
  // Unmapped addresses answer with an error so software notices a bad pointer
  assign pslverr = psel && penable && !hit;

  // ============================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end
    else
    begin
      sync1_r <= {cmp_b_raw, cmp_a_raw}; // [RULE16]
      sync2_r <= sync1_r;                // [RULE16]
    end
  end

  // ============================================================
  // Results after inversion
  logic [1:0] result;
  logic [1:0] inv;
  logic [1:0] on;
  assign inv    = {cmp_ctrl_r[`DCC_B_B_INV], cmp_ctrl_r[`DCC_B_A_INV]};
  assign on     = {cmp_ctrl_r[`DCC_B_B_ON], cmp_ctrl_r[`DCC_B_A_ON]};
  // A disabled comparator reads as its idle low level before inversion
  assign result = (sync2_r & on) ^ inv; // [RULE5] [RULE6]

  // Change detection; previous value is primed once after reset
  logic [1:0] change;
  assign change = prev_valid_r ? (result ^ prev_r) : 2'h0; // [RULE2]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r <= 2'h0;
    end
    else
    begin
      prev_r <= result;
    end
  end

  // Masks the first cycle, before prev_r has held a real result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_valid_r <= 1'b0;
    end
    else
    begin
      prev_valid_r <= 1'b1;
    end
  end

  // ============================================================
  // Comparator control register
  logic [15:0] cmp_wmask;
  logic        cmp_wr;
  assign cmp_wr    = wr_en && is_addr(addr_w, `DCC_OFS_CMP_CTRL);
  // Result bits and the spare bit take no writes
  assign cmp_wmask = strb16 & 16'(`DCC_WMASK_CMP); // [RULE14]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_ctrl_r <= `DCC_RST_CMP_CTRL;
    end
    else
    begin
      if (cmp_wr)
      begin
        cmp_ctrl_r <= (cmp_ctrl_r & ~cmp_wmask) | (wdata16 & cmp_wmask); // [RULE14]
      end
      // Flags are sticky: a change in the clearing cycle still sets them
      if (change[1])
      begin
        cmp_ctrl_r[`DCC_B_B_FLAG] <= 1'b1; // [RULE2] [RULE15]
      end
      if (change[0])
      begin
        cmp_ctrl_r[`DCC_B_A_FLAG] <= 1'b1; // [RULE2] [RULE15]
      end
    end
  end

  // ============================================================
  // Reference ladder control register
  logic ladder_wr;
  assign ladder_wr = wr_en && is_addr(addr_w, `DCC_OFS_LADDER_CTRL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ladder_ctrl_r <= `DCC_RST_LADDER_CTRL;
    end
    else if (ladder_wr && pstrb[0])
    begin
      ladder_ctrl_r <= wdata16 & 16'(`DCC_WMASK_LADDER); // [RULE14]
    end
  end

  // ============================================================
  // Interrupt status, mask and mode
  logic st_rd;
  logic [1:0] suppress_n;
  assign st_rd = rd_en && is_addr(addr_w, `DCC_OFS_IRQ_STATUS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_r <= 2'h0;
    end
    else
    begin
      // Only the bits that the read returned are cleared, so an event that
      // lands in the setup cycle survives; a new event wins over the clear
      irq_status_r <= (st_rd ? (irq_status_r & ~prdata[1:0]) : irq_status_r) | change;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_r <= 2'h0;
    end
    else if (reg_wr(`DCC_OFS_IRQ_MASK))
    begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_int_en_r <= 1'b0;
    end
    else if (reg_wr(`DCC_OFS_MODE))
    begin
      mode_int_en_r <= pwdata[0];
    end
  end

  logic suppressed;
  // Idle suppression gates the request only; flags and status still record
  assign suppressed = cmp_ctrl_r[`DCC_B_IDLE_SUPP] && idle_mode; // [RULE1]
  assign suppress_n = {2{!suppressed}};

  logic [1:0] flags;
  assign flags = {cmp_ctrl_r[`DCC_B_B_FLAG], cmp_ctrl_r[`DCC_B_A_FLAG]};

  // Level request: sticky status gated by mask, or flag request when enabled
  logic irq_nxt;
  always_comb
  begin
    irq_nxt = |(((irq_status_r & irq_mask_r) | (flags & {2{mode_int_en_r}}))
                & suppress_n); // [RULE1] [RULE15]
  end

  // Registered so the pin never glitches while the status bits settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_nxt;
    end
  end

  // ============================================================
  // Read mux
  logic [15:0] cmp_view;
  always_comb
  begin
    cmp_view                   = cmp_ctrl_r;
    cmp_view[`DCC_B_RSVD14]    = 1'b0;            // [RULE14]
    cmp_view[`DCC_B_B_RESULT]  = result[1];       // [RULE5]
    cmp_view[`DCC_B_A_RESULT]  = result[0];       // [RULE5]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    // Loaded in the setup cycle so the data stands at the access edge
    else if (psel && !penable && !pwrite)
    begin
      unique case (1'b1)
        is_addr(addr_w, `DCC_OFS_CMP_CTRL):    prdata <= {16'h0000, cmp_view};
        is_addr(addr_w, `DCC_OFS_LADDER_CTRL): prdata <= {16'h0000, ladder_ctrl_r}; // [RULE14]
        is_addr(addr_w, `DCC_OFS_IRQ_STATUS):  prdata <= {30'h0, irq_status_r};
        is_addr(addr_w, `DCC_OFS_IRQ_MASK):    prdata <= {30'h0, irq_mask_r};
        is_addr(addr_w, `DCC_OFS_MODE):        prdata <= {31'h0, mode_int_en_r};
        default:                               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // Analog controls
  assign cmp_a_on           = cmp_ctrl_r[`DCC_B_A_ON];    // [RULE3]
  assign cmp_b_on           = cmp_ctrl_r[`DCC_B_B_ON];    // [RULE3]
  assign cmp_a_minus_select = cmp_ctrl_r[`DCC_B_A_MINUS]; // [RULE7]
  assign cmp_b_minus_select = cmp_ctrl_r[`DCC_B_B_MINUS]; // [RULE7]
  assign cmp_a_plus_select  = cmp_ctrl_r[`DCC_B_A_PLUS];  // [RULE8]
  assign cmp_b_plus_select  = cmp_ctrl_r[`DCC_B_B_PLUS];  // [RULE8]

  // ============================================================
  // Output pads
  // Pad data comes from flops: one more cycle of latency than the result
  // bits, traded for an output that cannot glitch on a register write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_pad_out <= 1'b0;
      cmp_b_pad_out <= 1'b0;
    end
    else
    begin
      cmp_a_pad_out <= result[0]; // [RULE4] [RULE6]
      cmp_b_pad_out <= result[1]; // [RULE4] [RULE6]
    end
  end

  assign cmp_a_pad_oe_n = !cmp_ctrl_r[`DCC_B_A_PAD]; // [RULE4]
  assign cmp_b_pad_oe_n = !cmp_ctrl_r[`DCC_B_B_PAD]; // [RULE4]

  assign ladder_power_on      = ladder_ctrl_r[`DCC_B_LAD_POWER];  // [RULE9]
  assign ladder_pin_drive     = ladder_ctrl_r[`DCC_B_LAD_PIN];    // [RULE10]
  assign ladder_source_select = ladder_ctrl_r[`DCC_B_LAD_SOURCE]; // [RULE12]

  // Range as a named type: zero-based coarse steps or quarter-based fine steps
  dcc_pkg::dcc_range_e ladder_range;
  assign ladder_range        = dcc_pkg::dcc_range_e'(ladder_ctrl_r[`DCC_B_LAD_RANGE]);
  assign ladder_range_select = (ladder_range == dcc_pkg::DCC_RANGE_ZERO); // [RULE11]

  // Tap index into the analog ladder; step and offset follow the range bit
  dcc_pkg::dcc_code_t level_code;
  assign level_code        = ladder_ctrl_r[`DCC_B_LAD_CODE_HI:0];
  assign ladder_level_code = level_code; // [RULE13] [RULE11]

endmodule : dcc_top

// File: verification/dcc_checker_properties.sv
// Port-level assertions for the dual comparator control block.
// Assumes a single pclk domain and a bind from the testbench top file.
`timescale 1ns/1ns
module dcc_checker #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and APB
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  // Comparator side
  input wire logic              idle_mode,
  input wire logic              cmp_a_raw,
  input wire logic              cmp_a_on,
  input wire logic              cmp_b_on,
  input wire logic              cmp_a_minus_select,
  input wire logic              cmp_b_minus_select,
  input wire logic              cmp_a_plus_select,
  input wire logic              cmp_b_plus_select,
  input wire logic              cmp_a_pad_out,
  input wire logic              cmp_a_pad_oe_n,
  input wire logic              cmp_b_pad_oe_n,
  // Ladder and interrupt
  input wire logic              ladder_power_on,
  input wire logic              ladder_pin_drive,
  input wire logic              ladder_range_select,
  input wire logic              ladder_source_select,
  input wire logic [3:0]        ladder_level_code,
  input wire logic              irq
);
  // ============================================================
  // Helpers
  logic wc;
  logic wl;
  logic mute_r;
  assign wc = psel && penable && pwrite && paddr == ADDR_W'(12'h000);
  assign wl = psel && penable && pwrite && paddr == ADDR_W'(12'h004);
  // Mirror of the idle suppression bit, since it has no port of its own
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mute_r <= 1'b0;
    else if (wc && pstrb[1])
      mute_r <= pwdata[15];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_raw_edge;
    cmp_a_on && $changed(cmp_a_raw);
  endsequence
  sequence s_mute;
    (mute_r && idle_mode) [*3];
  endsequence
  // ============================================================
  // Assertions
  a_pad_drive: assert property (wc && pstrb[1] |=>
    {cmp_b_pad_oe_n, cmp_a_pad_oe_n} == ~$past(pwdata[9:8])) else $error("pad enable wrong");
  a_cmp_on: assert property (wc && pstrb[1] |=>
    {cmp_b_on, cmp_a_on} == $past(pwdata[11:10])) else $error("enable wrong");
  a_routing: assert property (wc && pstrb[0] |=> {cmp_b_minus_select,
    cmp_b_plus_select, cmp_a_minus_select, cmp_a_plus_select} == $past(pwdata[3:0]))
    else $error("routing wrong");
  a_ladder_pow: assert property (wl && pstrb[0] |=>
    ladder_power_on == $past(pwdata[7])) else $error("ladder power wrong");
  a_ladder_pin: assert property (wl && pstrb[0] |=>
    ladder_pin_drive == $past(pwdata[6])) else $error("ladder pin wrong");
  a_ladder_mode: assert property (wl && pstrb[0] |=>
    {ladder_range_select, ladder_source_select, ladder_level_code} == $past(pwdata[5:0]))
    else $error("ladder mode wrong");
  a_sync_path: assert property (s_raw_edge |-> ##[1:3] ($changed(cmp_a_pad_out) || wc))
    else $error("pad did not follow output");
  a_idle_mute: assert property (s_mute |-> !irq)
    else $error("irq while suppressed");
  a_irq_sticky: assert property ($fell(irq) |-> $past(psel) || $past(psel, 2)
    || $past(idle_mode)) else $error("irq dropped by itself");
endmodule : dcc_checker

// File: verification/dcc_cmp_model.sv
// Behavioural analog comparator with routing muxes and reference ladder.
// Assumes a unit span, so the source select has no visible effect here.
`timescale 1ns/1ns
module dcc_cmp_model (
  // Controls
  input wire logic       on,
  input wire logic       plus_sel,
  input wire logic       minus_sel,
  input wire logic       lad_rng,
  input wire logic [3:0] code,
  // Pin levels, fractions of the span
  input real             vp,
  input real             vm,
  // Decision
  output logic           raw
);
  real vref;
  real pos;
  real neg;
  // A powered-down comparator is held low rather than left floating
  always_comb
  begin
    vref = lad_rng ? code / 24.0 : 0.25 + code / 32.0;
    pos = plus_sel ? vp : vref;
    neg = minus_sel ? vp : vm;
    raw = on && (pos > neg);
  end
endmodule : dcc_cmp_model

// File: verification/dual_comparator_control_tb.sv
// Self-checking bench for the dual comparator control block.
// Assumes APB with zero wait states tolerated but not relied on.
`timescale 1ns/1ns
module dual_comparator_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, idle_mode, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, ladder_level_code;
  logic cmp_a_raw, cmp_b_raw, cmp_a_on, cmp_b_on, err;
  logic cmp_a_minus_select, cmp_b_minus_select, cmp_a_plus_select, cmp_b_plus_select;
  logic cmp_a_pad_out, cmp_a_pad_oe_n, cmp_b_pad_out, cmp_b_pad_oe_n;
  logic ladder_power_on, ladder_pin_drive, ladder_range_select, ladder_source_select;
  real va_p, va_m, vb_p, vb_m;
  int miscompares, tests_run;
  dcc_top #(.ADDR_W(12)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .idle_mode, .cmp_a_raw, .cmp_b_raw,
    .cmp_a_on, .cmp_b_on, .cmp_a_minus_select, .cmp_b_minus_select, .cmp_a_plus_select,
    .cmp_b_plus_select, .cmp_a_pad_out, .cmp_a_pad_oe_n, .cmp_b_pad_out, .cmp_b_pad_oe_n,
    .ladder_power_on, .ladder_pin_drive, .ladder_range_select, .ladder_source_select,
    .ladder_level_code, .irq);
  dcc_cmp_model i_cmp_a (.on(cmp_a_on), .plus_sel(cmp_a_plus_select),
    .minus_sel(cmp_a_minus_select), .lad_rng(ladder_range_select),
    .code(ladder_level_code), .vp(va_p), .vm(va_m), .raw(cmp_a_raw));
  dcc_cmp_model i_cmp_b (.on(cmp_b_on), .plus_sel(cmp_b_plus_select),
    .minus_sel(cmp_b_minus_select), .lad_rng(ladder_range_select),
    .code(ladder_level_code), .vp(vb_p), .vm(vb_m), .raw(cmp_b_raw));
  always #50 pclk = ~pclk;
  // ============================================================
  // Shared tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ============================================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, 12'h000, 16'h0);
    chk(rd, 32'h0);
    chk(32'({cmp_a_pad_oe_n, cmp_b_pad_oe_n, irq}), 32'h6);
    apb(1'b1, 12'h000, 16'hf0ff);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 16'h0);
    chk(rd, 32'hb0ff);
    apb(1'b1, 12'h004, 16'hffff);
    apb(1'b0, 12'h004, 16'h0);
    chk(rd, 32'hff);
    chk(32'({ladder_power_on, ladder_pin_drive, ladder_range_select,
      ladder_source_select, ladder_level_code}), 32'hff);
    apb(1'b0, 12'h014, 16'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 12'h004, 16'h0);
    apb(1'b1, 12'h000, 16'h0);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h008, 16'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_change;
    apb(1'b1, 12'h010, 16'h1);
    apb(1'b1, 12'h00c, 16'h3);
    apb(1'b1, 12'h000, 16'h0501);
    apb(1'b0, 12'h008, 16'h0);
    va_p <= 0.9;
    repeat (5) @(posedge pclk);
    chk(32'({cmp_a_pad_out, cmp_a_pad_oe_n, irq}), 32'h5);
    apb(1'b0, 12'h000, 16'h0);
    chk(rd, 32'h1541);
    apb(1'b0, 12'h008, 16'h0);
    chk(rd, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h000, 16'h0511);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 16'h0);
    chk(rd, 32'h1511);
    apb(1'b1, 12'h000, 16'h0411);
    apb(1'b0, 12'h008, 16'h0);
    repeat (3) @(posedge pclk);
    chk(32'({cmp_a_pad_oe_n, irq}), 32'h2);
    $display("t_change done");
  endtask : t_change
  task automatic t_idle;
    idle_mode <= 1'b1;
    apb(1'b1, 12'h000, 16'h8804);
    apb(1'b0, 12'h008, 16'h0);
    vb_p <= 0.9;
    repeat (6) @(posedge pclk);
    chk(32'(irq), 32'h0);
    chk(32'({cmp_b_pad_out, cmp_b_pad_oe_n}), 32'h3);
    apb(1'b0, 12'h000, 16'h0);
    chk(rd, 32'ha884);
    idle_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h000, 16'h0);
    $display("t_idle done");
  endtask : t_idle
  task automatic t_ladder;
    real vref;
    va_m <= 0.45;
    apb(1'b1, 12'h000, 16'h0400);
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 16; c++)
      begin
        vref = (r == 1) ? c / 24.0 : 0.25 + c / 32.0;
        apb(1'b1, 12'h004, 16'(8'h80 | (r << 5) | c));
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h000, 16'h0);
        chk(32'(rd[6]), 32'(vref > 0.45));
      end
    $display("t_ladder done");
  endtask : t_ladder
  // ============================================================
  // Main sequence and watchdog
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, idle_mode} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    va_p = 0.2;
    va_m = 0.6;
    vb_p = 0.1;
    vb_m = 0.5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_change;
    t_idle;
    t_ladder;
    tally_and_finish;
  end
  initial
  begin
    #3000000;
    miscompares++;
    tally_and_finish;
  end
endmodule : dual_comparator_control_tb
bind dcc_top dcc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .idle_mode, .cmp_a_raw, .cmp_a_on, .cmp_b_on,
  .cmp_a_minus_select, .cmp_b_minus_select, .cmp_a_plus_select, .cmp_b_plus_select,
  .cmp_a_pad_out, .cmp_a_pad_oe_n, .cmp_b_pad_oe_n, .ladder_power_on, .ladder_pin_drive,
  .ladder_range_select, .ladder_source_select, .ladder_level_code, .irq);
